/* File: tb/spdif_rx_input_and_status_tb.sv */
// self-checking bench for receiver input selection, sample shaping and status capture
`default_nettype none
module spdif_rx_input_and_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, reg_wr, reg_rd, primary_rx_pin, dac_src_rx, tx_src_rx;
  logic multifunction_pin_a_in, multifunction_pin_b_in, multifunction_pin_c_in;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] aif_len_code;
  logic sub_strobe, sub_second_channel, sub_block_start;
  logic [31:0] sub_word, aif_sample;
  logic multifunction_pin_a_out, multifunction_pin_a_oe, multifunction_pin_b_out;
  logic multifunction_pin_b_oe, multifunction_pin_c_out, sample_second_channel, sample_parity;
  logic dac_valid, tx_valid;
  logic multifunction_pin_c_oe, primary_pin_circuit_sel, rx_line, rx_enable, rx_source_fault;
  logic sample_valid, sample_validity, sample_user, sample_cstat, parity_error;
  logic first_dac_mute, first_dac_pre_emphasis_flag, status_update_flag;
  logic [2:0] alt_input_comparator;
  logic [23:0] dac_left, dac_right, tx_sample;
  logic [39:0] cs;
  int errors = 0;
  int total_checks = 0;
  typedef struct packed {
    logic [23:0] smp;
    logic [1:0] audio_data_interface;
    logic byp;
    logic [2:0] vuc;
    logic [31:0] aif_exp;
    logic [23:0] tx_exp;
  } row_t;
  // captured length is 21 bits, so unbypassed words lose their 3 lowest bits
  row_t rows [4] = '{
    '{24'hABCDEF, 2'h0, 1'b0, 3'b100, 32'hABCD0000, 24'hABCDE8},
    '{24'hABCDEF, 2'h2, 1'b0, 3'b010, 32'hABCDE800, 24'hABCDE8},
    '{24'hABCDEF, 2'h3, 1'b1, 3'b001, 32'hABCDEF00, 24'hABCDEF},
    '{24'h12345F, 2'h1, 1'b1, 3'b111, 32'h12345000, 24'h12345F}};

  spdif_rx_input_and_status dut_u (.*);
  spdif_source src_u (.ref_clk, .sub_strobe, .sub_word, .sub_second_channel, .sub_block_start);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, e, "register read");
  endtask : rd
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // a whole run is a few hundred cycles
  initial begin
    #100us;
    errors++;
    end_of_test();
  end
  initial begin
    {rstn, reg_wr, reg_rd, primary_rx_pin, reg_addr, reg_wdata, aif_len_code} = '0;
    {multifunction_pin_a_in, multifunction_pin_b_in, multifunction_pin_c_in} = '0;
    {dac_src_rx, tx_src_rx} = 2'b11;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    chk(rx_enable, 0, "rx enable");
    chk(primary_pin_circuit_sel, 1, "circuit");
    chk(multifunction_pin_c_out, 0, "idle pin c");
    rd(7'h24, 8'h01);
    rd(7'h27, 8'h32);
    rd(7'h28, 8'h04);
    rd(7'h33, 8'h20);
    wr(7'h2C, 8'hFF);
    rd(7'h2C, 8'h00);
    rd(7'h7E, 8'h00);
    src_u.send(1'b0, 1'b0, 24'h123456, 3'b111);
    chk(sample_valid, 0, "taken while off");
    wr(7'h33, 8'h00);
    chk(rx_enable, 1, "rx enable");
    wr(7'h27, 8'h89);
    chk(multifunction_pin_b_oe, 1, "user pin drives");
    // pre-emphasis, pcm, maximum 24 bits with code 110: 21 bit samples
    cs = 40'h0D5A3CA508;
    src_u.send_block(cs, 24'h000000);
    chk(status_update_flag, 1, "flag set");
    chk(multifunction_pin_a_out, 1, "flag pin");
    chk(first_dac_pre_emphasis_flag, 1, "de-emphasis");
    chk(first_dac_mute, 0, "pcm mute");
    rd(7'h2C, cs[7:0]);
    chk(status_update_flag, 0, "flag clear");
    chk(multifunction_pin_a_out, 0, "flag pin");
    for (int i = 1; i < 5; i++) rd(7'h2C + 7'(i), cs[8*i+:8]);
    foreach (rows[i]) begin
      aif_len_code = rows[i].audio_data_interface;
      wr(7'h24, {1'b0, rows[i].byp, 6'h01});
      src_u.send(1'b0, 1'b0, rows[i].smp, rows[i].vuc);
      chk(sample_valid, 1, "valid");
      chk(aif_sample, rows[i].aif_exp, "aif word");
      chk(tx_sample, rows[i].tx_exp, "tx word");
      chk(dac_left, rows[i].tx_exp, "dac word");
      chk({sample_validity, sample_user, sample_cstat, parity_error}, {rows[i].vuc, 1'b0},
          "vucp");
      chk(multifunction_pin_b_out, rows[i].vuc[1], "user pin");
    end
    // channel 2 with the transmitter off: right dac word pairs up, transmitter word holds
    tx_src_rx = 1'b0;
    src_u.send(1'b1, 1'b0, 24'h654321, 3'b000);
    chk(sample_second_channel, 1, "channel 2");
    chk(dac_valid, 1, "dac pair");
    chk(dac_right, 24'h654321, "dac right word");
    chk(tx_valid, 0, "tx off");
    chk(tx_sample, 24'h12345F, "tx held");
    tx_src_rx = 1'b1;
    // odd parity over slots 4..31 must be flagged
    src_u.send_word(1'b0, 1'b0, 32'h00000010);
    chk(parity_error, 1, "bad parity");
    chk(sample_parity, 0, "parity slot");
    src_u.send_block(40'h0D5A3CA502, 24'h000000);
    chk(first_dac_mute, 1, "non-audio mute");
    chk(first_dac_pre_emphasis_flag, 0, "no pre-emphasis");
    chk(status_update_flag, 1, "flag held unread");
    dac_src_rx = 1'b0;
    #1;
    chk(first_dac_mute, 0, "mute off route");
    // reset in mid-run drops the captured status and the flag at once
    @(negedge ref_clk);
    rstn = 1'b0;
    #1;
    chk(status_update_flag, 0, "flag reset");
    @(negedge ref_clk);
    rstn = 1'b1;
    rd(7'h30, 8'h00);
    rd(7'h33, 8'h20);
    wr(7'h33, 8'h00);
    wr(7'h28, 8'h0E);
    wr(7'h24, 8'h06);
    chk(primary_pin_circuit_sel, 0, "cmos circuit");
    chk(multifunction_pin_c_oe, 0, "input pin oe");
    for (int v = 0; v < 2; v++) begin
      @(negedge ref_clk);
      multifunction_pin_c_in = v[0];
      #1;
      chk(rx_line, v, "pin c line");
    end
    wr(7'h24, 8'h04);
    chk(rx_source_fault, 1, "not an input");
    chk(rx_line, 0, "faulted line");
    wr(7'h28, 8'h0F);
    chk(alt_input_comparator, 3'b100, "comparator pin");
    primary_rx_pin = 1'b1;
    wr(7'h24, 8'h01);
    chk(rx_line, 1, "primary line");
    wr(7'h33, 8'h20);
    chk(rx_line, 0, "powered down line");
    end_of_test();
  end
endmodule : spdif_rx_input_and_status_tb
`default_nettype wire

/* File: tb/spdif_rx_monitor.sv */
// concurrent checks on the receiver input, sample and status ports
`default_nettype none
module spdif_rx_monitor (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [6:0] reg_addr,
  input wire logic reg_rd,
  input wire logic sub_strobe,
  input wire logic [31:0] sub_word,
  input wire logic sub_second_channel,
  input wire logic [1:0] aif_len_code,
  input wire logic dac_src_rx,
  input wire logic tx_src_rx,
  input wire logic rx_enable,
  input wire logic rx_line,
  input wire logic rx_source_fault,
  input wire logic sample_valid,
  input wire logic sample_second_channel,
  input wire logic sample_cstat,
  input wire logic [31:0] aif_sample,
  input wire logic first_dac_mute,
  input wire logic first_dac_pre_emphasis_flag,
  input wire logic tx_valid,
  input wire logic status_update_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // any status register read
  wire stat_rd = reg_rd && reg_addr >= 7'h2C && reg_addr <= 7'h30;

  take_sub_a:
    assert property (sub_strobe && rx_enable |=> sample_valid) else $error("subframe lost");
  slot_copy_a:
    assert property (sample_valid |-> sample_cstat == $past(sub_word[30])
      && sample_second_channel == $past(sub_second_channel)) else $error("slot bits wrong");
  pd_drop_a:
    assert property (sub_strobe && !rx_enable |=> !sample_valid && !tx_valid)
      else $error("subframe taken while off");
  dead_line_a:
    assert property (!rx_enable || rx_source_fault |-> !rx_line) else $error("line live");
  fwd_tx_a:
    assert property (sub_strobe && rx_enable && tx_src_rx |=> tx_valid) else $error("no tx");
  rd_clear_a:
    assert property (stat_rd && !sub_strobe |=> !status_update_flag)
      else $error("flag kept after read");
  ch1_only_a:
    assert property ($rose(status_update_flag) |-> $past(sub_strobe)
      && !$past(sub_second_channel)) else $error("flag without channel 1 subframe");
  mute_src_a:
    assert property ($changed(first_dac_mute) |-> $changed(dac_src_rx)
      || ($past(sub_strobe) && !$past(sub_second_channel))) else $error("mute moved alone");
  pre_emphasis_flag_src_a:
    assert property ($changed(first_dac_pre_emphasis_flag) |-> $changed(dac_src_rx)
      || ($past(sub_strobe) && !$past(sub_second_channel))) else $error("de-emphasis moved alone");
  aif_trim_a:
    assert property (sample_valid && $past(aif_len_code) == 2'h0
      |-> aif_sample[15:0] == 16'h0000) else $error("16 bit word not trimmed");
  aif_pad_a:
    assert property (sample_valid && $past(aif_len_code) == 2'h2
      |-> aif_sample[7:0] == 8'h00) else $error("24 bit word not padded");

  cover property (sample_valid && aif_len_code == 2'h0);
  cover property ($rose(status_update_flag));
  cover property (first_dac_mute);
endmodule : spdif_rx_monitor
bind spdif_rx_input_and_status spdif_rx_monitor mon_u (.*);
`default_nettype wire

/* File: tb/spdif_source.sv */
// behavioural far-end source handing decoded subframes to the receiver
`default_nettype none
module spdif_source (
  input wire logic ref_clk,
  output logic sub_strobe,
  output logic [31:0] sub_word,
  output logic sub_second_channel,
  output logic sub_block_start
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sub_strobe = 1'b0;
    sub_word = 32'h0000_0000;
    sub_second_channel = 1'b0;
    sub_block_start = 1'b0;
  end
  // one raw subframe word, so that broken parity can be offered as well
  task automatic send_word(input logic ch, input logic start, input logic [31:0] w);
    @(negedge ref_clk);
    sub_word = w;
    sub_second_channel = ch;
    sub_block_start = start;
    sub_strobe = 1'b1;
    @(negedge ref_clk);
    sub_strobe = 1'b0;
    sub_block_start = 1'b0;
    sub_word = ~w; // no stale word outside the strobe
  endtask : send_word
  // one subframe; vuc is validity, user, status; parity slot keeps slots 4..31 even
  task automatic send(input logic ch, input logic start, input logic [23:0] smp,
                      input logic [2:0] vuc);
    logic [31:0] w;
    w = {1'b0, vuc[0], vuc[1], vuc[2], smp, 4'h0};
    w[31] = ^w[30:4];
    send_word(ch, start, w);
  endtask : send
  // whole status block, status bit k rides on the k-th channel 1 subframe
  task automatic send_block(input logic [39:0] cs, input logic [23:0] smp);
    for (int k = 0; k < 40; k++) begin
      send(1'b0, k == 0, smp, {2'b00, cs[k]});
      send(1'b1, 1'b0, smp, 3'b000);
    end
  endtask : send_block
endmodule : spdif_source
`default_nettype wire

/* File: verilog/sample_shaper.sv */
// word length truncation and audio interface fitting of one received sample
`default_nettype none
module sample_shaper
  import spdif_rx_pkg::*;
(
  input wire logic [23:0] sample,
  input wire logic [4:0] rx_len,
  input wire logic bypass,
  input wire logic [1:0] aif_len_code,
  output logic [23:0] tx_word,
  output logic [31:0] aif_word
);
  wire logic [23:0] len_mask;
  wire logic [31:0] aif_mask;
  wire logic [5:0] aif_width;

  // keep the top rx_len bits unless the bypass is set
  assign len_mask = ~(24'hFFFFFF >> rx_len);
  assign tx_word = bypass ? sample : (sample & len_mask);
  // left justified: short interface drops lsbs, long one gets zero lsbs
  assign aif_width = aif_bits(aif_len_code);
  assign aif_mask = ~(32'hFFFFFFFF >> aif_width);
  assign aif_word = {tx_word, 8'h00} & aif_mask;
endmodule : sample_shaper
`default_nettype wire

/* File: verilog/spdif_rx_input_and_status.sv */
// receiver input selection, subframe unpacking, sample routing and channel status capture
`default_nettype none
module spdif_rx_input_and_status
  import spdif_rx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic primary_rx_pin,
  input wire logic multifunction_pin_a_in,
  output logic multifunction_pin_a_out,
  output logic multifunction_pin_a_oe,
  input wire logic multifunction_pin_b_in,
  output logic multifunction_pin_b_out,
  output logic multifunction_pin_b_oe,
  input wire logic multifunction_pin_c_in,
  output logic multifunction_pin_c_out,
  output logic multifunction_pin_c_oe,
  output logic primary_pin_circuit_sel,
  output logic [2:0] alt_input_comparator,
  output logic rx_line,
  output logic rx_enable,
  output logic rx_source_fault,
  input wire logic sub_strobe,
  input wire logic [31:0] sub_word,
  input wire logic sub_second_channel,
  input wire logic sub_block_start,
  input wire logic [1:0] aif_len_code,
  input wire logic dac_src_rx,
  input wire logic tx_src_rx,
  output logic sample_valid,
  output logic sample_second_channel,
  output logic sample_validity,
  output logic sample_user,
  output logic sample_cstat,
  output logic sample_parity,
  output logic parity_error,
  output logic [31:0] aif_sample,
  output logic [23:0] dac_left,
  output logic [23:0] dac_right,
  output logic dac_valid,
  output logic first_dac_mute,
  output logic first_dac_pre_emphasis_flag,
  output logic [23:0] tx_sample,
  output logic tx_valid,
  output logic status_update_flag
);
  logic [7:0] rx_input_mode;
  logic [7:0] mfp_config_a;
  logic [7:0] mfp_config_b;
  logic [7:0] power_down_ctrl_b;
  logic [7:0] rx_status [0:RX_STATUS_REGS-1];
  logic [39:0] cs_shift;
  logic [5:0] cs_count;
  cs_state_t cs_state;
  logic user_bit;

  wire logic [1:0] rx_source_select;
  wire logic truncation_bypass;
  wire logic receiver_power_down;
  wire logic [3:0] pin_fn [0:2];
  wire logic [2:0] pin_in;
  wire logic [2:0] pin_is_input;
  wire logic [2:0] pin_out;
  wire logic [2:0] pin_oe;
  wire logic [3:0] sel_onehot;
  wire logic sel_ok;
  wire logic take_sub;
  wire logic [23:0] raw_sample;
  wire logic odd_parity;
  wire logic cs_take;
  wire logic cs_done;
  wire logic status_read;
  wire logic [4:0] rx_len;
  wire logic [23:0] next_tx_word;
  wire logic [31:0] next_aif_word;
  wire logic wr_mode;
  wire logic wr_cfg_a;
  wire logic wr_cfg_b;
  wire logic wr_pwr;
  wire logic status_hit;
  wire logic [2:0] status_idx;
  wire logic [7:0] next_rdata;

  // control fields
  assign primary_pin_circuit_sel = rx_input_mode[PRIMARY_CIRCUIT_BIT];
  assign rx_source_select = rx_input_mode[SRC_SEL_LSB+:2];
  assign truncation_bypass = rx_input_mode[BYPASS_BIT];
  assign receiver_power_down = power_down_ctrl_b[RX_PD_BIT];
  assign rx_enable = ~receiver_power_down;
  assign pin_fn[0] = mfp_config_a[3:0];
  assign pin_fn[1] = mfp_config_a[7:4];
  assign pin_fn[2] = mfp_config_b[3:0];
  assign pin_in = {multifunction_pin_c_in, multifunction_pin_b_in, multifunction_pin_a_in};

  // per-pin direction and output function; a receive pin never drives
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pin
      assign pin_is_input[p] = (pin_fn[p] == MFP_CMOS_IN) | (pin_fn[p] == MFP_COMP_IN);
      assign alt_input_comparator[p] = (pin_fn[p] == MFP_COMP_IN);
      assign pin_oe[p] = ~pin_is_input[p];
      assign pin_out[p] = ((pin_fn[p] == MFP_USER_DATA) & user_bit)
                        | ((pin_fn[p] == MFP_STATUS_FLAG) & status_update_flag);
    end
  endgenerate

  assign multifunction_pin_a_out = pin_out[0];
  assign multifunction_pin_b_out = pin_out[1];
  assign multifunction_pin_c_out = pin_out[2];
  assign multifunction_pin_a_oe = pin_oe[0];
  assign multifunction_pin_b_oe = pin_oe[1];
  assign multifunction_pin_c_oe = pin_oe[2];

  // input mux: an alternate pin not set up as input feeds a quiet line
  assign sel_onehot = 4'h1 << rx_source_select;
  assign sel_ok = sel_onehot[0] | |(sel_onehot[3:1] & pin_is_input);
  assign rx_source_fault = ~sel_ok;
  assign rx_line = rx_enable & sel_ok
                 & |(sel_onehot & {pin_in, primary_rx_pin});

  // subframe unpacking; decoder results are ignored while powered down
  assign take_sub = sub_strobe & rx_enable;
  assign raw_sample = sub_word[SAMPLE_MSB:SAMPLE_LSB];
  assign odd_parity = ^sub_word[SLOT_PARITY:SAMPLE_LSB];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sample_valid <= 1'b0;
      sample_second_channel <= 1'b0;
      sample_validity <= 1'b0;
      sample_user <= 1'b0;
      sample_cstat <= 1'b0;
      sample_parity <= 1'b0;
      parity_error <= 1'b0;
      user_bit <= 1'b0;
    end else begin
      sample_valid <= take_sub;
      parity_error <= take_sub & odd_parity;
      if (take_sub) begin
        sample_second_channel <= sub_second_channel;
        sample_validity <= sub_word[SLOT_VALIDITY];
        sample_user <= sub_word[SLOT_USER];
        sample_cstat <= sub_word[SLOT_CSTAT];
        sample_parity <= sub_word[SLOT_PARITY];
        user_bit <= sub_word[SLOT_USER];
      end
    end
  end

  // length from the last captured status; the source must fill it in
  assign rx_len = sample_length(rx_status[4][0], rx_status[4][3:1]);

  sample_shaper u_shaper (
    .sample(raw_sample),
    .rx_len(rx_len),
    .bypass(truncation_bypass),
    .aif_len_code(aif_len_code),
    .tx_word(next_tx_word),
    .aif_word(next_aif_word)
  );

  // sample outputs: interface always updated, dac and transmitter each optional
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aif_sample <= 32'h00000000;
      tx_sample <= 24'h000000;
      tx_valid <= 1'b0;
      dac_left <= 24'h000000;
      dac_right <= 24'h000000;
      dac_valid <= 1'b0;
    end else begin
      tx_valid <= take_sub & tx_src_rx;
      dac_valid <= take_sub & dac_src_rx & sub_second_channel;
      if (take_sub) begin
        aif_sample <= next_aif_word;
        if (tx_src_rx) begin
          tx_sample <= next_tx_word;
        end
        if (dac_src_rx & ~sub_second_channel) begin
          dac_left <= next_tx_word;
        end
        if (dac_src_rx & sub_second_channel) begin
          dac_right <= next_tx_word;
        end
      end
    end
  end

  // dac control follows captured status while the receiver feeds the dac
  assign first_dac_mute = dac_src_rx & rx_status[0][CS_NON_AUDIO];
  assign first_dac_pre_emphasis_flag = dac_src_rx & rx_status[0][CS_PRE_EMPH];

  // status collection: ch1 bits only, aligned to block start
  assign cs_take = take_sub & ~sub_second_channel;
  assign cs_done = cs_take & (cs_state == CS_COLLECT) & (cs_count == CS_LAST_BIT);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_state <= CS_WAIT;
      cs_count <= 6'h00;
      cs_shift <= 40'h0000000000;
    end else if (cs_take) begin
      unique case (cs_state)
        CS_WAIT: begin
          if (sub_block_start) begin
            cs_state <= CS_COLLECT;
            cs_count <= 6'h01;
            cs_shift[0] <= sub_word[SLOT_CSTAT];
          end
        end
        CS_COLLECT: begin
          cs_shift[cs_count] <= sub_word[SLOT_CSTAT];
          cs_count <= cs_count + 6'h01;
          if (cs_count == CS_LAST_BIT) begin
            cs_state <= CS_WAIT;
          end
        end
      endcase
    end
  end

  // complete block lands in the five read-only registers at once
  genvar r;
  generate
    for (r = 0; r < RX_STATUS_REGS; r++) begin : g_status
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          rx_status[r] <= 8'h00;
        end else if (cs_done) begin
          if (r == RX_STATUS_REGS - 1) begin
            rx_status[r] <= {sub_word[SLOT_CSTAT], cs_shift[8*r+6:8*r]};
          end else begin
            rx_status[r] <= cs_shift[8*r+:8];
          end
        end
      end
    end
  endgenerate

  // register port decode
  assign wr_mode = reg_wr & (reg_addr == ADDR_RX_INPUT_MODE);
  assign wr_cfg_a = reg_wr & (reg_addr == ADDR_MFP_CONFIG_A);
  assign wr_cfg_b = reg_wr & (reg_addr == ADDR_MFP_CONFIG_B);
  assign wr_pwr = reg_wr & (reg_addr == ADDR_POWER_DOWN_CTRL_B);
  assign status_hit = (reg_addr >= ADDR_RX_STATUS_FIRST) & (reg_addr <= ADDR_RX_STATUS_LAST);
  assign status_idx = 3'(reg_addr - ADDR_RX_STATUS_FIRST);
  assign status_read = reg_rd & status_hit;
  assign next_rdata = (reg_addr == ADDR_RX_INPUT_MODE) ? rx_input_mode
                    : (reg_addr == ADDR_MFP_CONFIG_A) ? mfp_config_a
                    : (reg_addr == ADDR_MFP_CONFIG_B) ? mfp_config_b
                    : (reg_addr == ADDR_POWER_DOWN_CTRL_B) ? power_down_ctrl_b
                    : status_hit ? rx_status[status_idx]
                    : 8'h00;

  // writable control registers; status registers ignore writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_input_mode <= RST_RX_INPUT_MODE;
      mfp_config_a <= RST_MFP_CONFIG_A;
      mfp_config_b <= RST_MFP_CONFIG_B;
      power_down_ctrl_b <= RST_POWER_DOWN_CTRL_B;
    end else begin
      if (wr_mode) begin
        rx_input_mode <= reg_wdata;
      end
      if (wr_cfg_a) begin
        mfp_config_a <= reg_wdata;
      end
      if (wr_cfg_b) begin
        mfp_config_b <= reg_wdata;
      end
      if (wr_pwr) begin
        power_down_ctrl_b <= reg_wdata;
      end
    end
  end

  // readback data and update flag; a fresh block wins over the clearing read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      status_update_flag <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
      if (cs_done) begin
        status_update_flag <= 1'b1;
      end else if (status_read) begin
        status_update_flag <= 1'b0;
      end
    end
  end
endmodule : spdif_rx_input_and_status
`default_nettype wire

/* File: verilog/spdif_rx_pkg.sv */
// constants shared by the receive input selector and status capture logic
`default_nettype none
package spdif_rx_pkg;
  // register addresses on the serial control port
  localparam logic [6:0] ADDR_RX_INPUT_MODE = 7'h24;
  localparam logic [6:0] ADDR_MFP_CONFIG_A = 7'h27;
  localparam logic [6:0] ADDR_MFP_CONFIG_B = 7'h28;
  localparam logic [6:0] ADDR_POWER_DOWN_CTRL_B = 7'h33;
  localparam logic [6:0] ADDR_RX_STATUS_FIRST = 7'h2C;
  localparam logic [6:0] ADDR_RX_STATUS_LAST = 7'h30;
  localparam int RX_STATUS_REGS = 5;

  // field positions
  localparam int PRIMARY_CIRCUIT_BIT = 0;
  localparam int SRC_SEL_LSB = 1;
  localparam int RX_PD_BIT = 5;
  localparam int BYPASS_BIT = 6;

  // reset values
  localparam logic [7:0] RST_RX_INPUT_MODE = 8'h01;
  localparam logic [7:0] RST_MFP_CONFIG_A = 8'h32;
  localparam logic [7:0] RST_MFP_CONFIG_B = 8'h04;
  localparam logic [7:0] RST_POWER_DOWN_CTRL_B = 8'h20;

  // multifunction pin function codes
  localparam logic [3:0] MFP_CMOS_IN = 4'hE;
  localparam logic [3:0] MFP_COMP_IN = 4'hF;
  localparam logic [3:0] MFP_USER_DATA = 4'h8;
  localparam logic [3:0] MFP_STATUS_FLAG = 4'h9;

  // subframe time slot positions
  localparam int SAMPLE_LSB = 4;
  localparam int SAMPLE_MSB = 27;
  localparam int SLOT_VALIDITY = 28;
  localparam int SLOT_USER = 29;
  localparam int SLOT_CSTAT = 30;
  localparam int SLOT_PARITY = 31;

  // channel status bit positions
  localparam int CS_NON_AUDIO = 1;
  localparam int CS_PRE_EMPH = 3;
  localparam int CS_MAX_LENGTH_FLAG = 32;
  localparam int CS_WL_LSB = 33;
  localparam logic [5:0] CS_LAST_BIT = 6'h27;

  localparam logic [4:0] FULL_LEN = 5'h18;

  typedef enum logic [1:0] {
    CS_WAIT = 2'b01,
    CS_COLLECT = 2'b10
  } cs_state_t;

  // sample length in bits from max length flag and length code
  function automatic logic [4:0] sample_length(input logic max_length_flag, input logic [2:0] code);
    logic [4:0] len;
    len = FULL_LEN;
    unique case (code)
      3'h1: len = max_length_flag ? 5'h14 : 5'h10;
      3'h2: len = max_length_flag ? 5'h16 : 5'h12;
      3'h4: len = max_length_flag ? 5'h17 : 5'h13;
      3'h5: len = max_length_flag ? 5'h18 : 5'h14;
      3'h6: len = max_length_flag ? 5'h15 : 5'h11;
      default: len = FULL_LEN;
    endcase
    return len;
  endfunction : sample_length

  // audio interface word length code to bits
  function automatic logic [5:0] aif_bits(input logic [1:0] code);
    logic [5:0] bits;
    bits = 6'h20;
    unique case (code)
      2'h0: bits = 6'h10;
      2'h1: bits = 6'h14;
      2'h2: bits = 6'h18;
      2'h3: bits = 6'h20;
    endcase
    return bits;
  endfunction : aif_bits
endpackage : spdif_rx_pkg
`default_nettype wire
